// file: echo_defs.svh
// register offsets, field positions, reset values and timing counts of the echo control block
`ifndef ECHO_DEFS_SVH
`define ECHO_DEFS_SVH
// register offsets on the byte-wide special-register port
`define REG_EN_CTRL       8'h00
`define REG_FIFO_CTRL     8'h01
`define REG_DECIM         8'h02
`define REG_BLANK_DELAY   8'h03
`define REG_SAT_DEGLITCH  8'h04
`define REG_SAT_CAPTURE   8'h05
`define REG_STATUS        8'h06
`define REG_SNAP_LSB      8'h07
`define REG_SNAP_MSB      8'h08
`define REG_RESULT_LSB    8'h09
`define REG_RESULT_MSB    8'h0a
// field positions
`define EN_ECHO_BIT       0
`define EN_SAT_BIT        1
`define EN_SNAP_BIT       2
`define ST_SAT_MEASURE_DONE_BIT   0
`define ST_OVERRUN_BIT    1
// reset values
`define RST_BYTE          8'h00
`define RST_DECIM         8'h19
`define RST_WORD          16'h0000
// timing
`define CLK_PERIOD_NS     8
`define TICK_US_NS        1000
`define CYC_PER_US        (`TICK_US_NS / `CLK_PERIOD_NS)
`define US_PER_DEGLITCH   2
`define US_PER_COARSE     16
`define SAT_LIMIT         8'hff
`endif

// file: echo_pkg.sv
// types shared by the echo control block and its output buffer
package echo_pkg;
   // fifo storage formats
   typedef enum logic [1:0] {
      FMT_FULL12 = 2'b00,
      FMT_MSB8   = 2'b01,
      FMT_LSB8   = 2'b10,
      FMT_MID8   = 2'b11
   } fifo_fmt_t;
   // byte writer states, one-hot
   typedef enum logic [2:0] {
      WR_IDLE  = 3'b001,
      WR_BYTE0 = 3'b010,
      WR_BYTE1 = 3'b100
   } wr_state_t;
   // one fifo byte write
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] data;
   } fifo_word_t;
endpackage

// file: pair_buffer.sv
// two-entry valid/ready buffer for fifo byte writes
`timescale 1ns/1ps
module pair_buffer (
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_in_valid,
   input  wire echo_pkg::fifo_word_t i_in_word,
   output logic                     o_in_ready,
   output logic                     o_out_valid,
   output echo_pkg::fifo_word_t     o_out_word,
   input  wire logic                i_out_ready
);
   logic                 head_vld_ff;   // entry 0 holds a word
   logic                 tail_vld_ff;   // entry 1 holds a word
   echo_pkg::fifo_word_t head_ff;       // word shown to the drain side
   echo_pkg::fifo_word_t tail_ff;       // spare entry taken on a stall
   wire                  pop  = head_vld_ff & i_out_ready;
   wire                  push = i_in_valid & ~tail_vld_ff;

   // ready and valid come straight from flops, so neither side sees a comb path
   assign o_in_ready  = ~tail_vld_ff;
   assign o_out_valid = head_vld_ff;
   assign o_out_word  = head_ff;

   // shift tail into head on pop, place new word in the first free slot
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         head_vld_ff <= 1'b0;
         tail_vld_ff <= 1'b0;
         head_ff     <= '0;
         tail_ff     <= '0;
      end else begin
         if (pop) begin
            head_vld_ff <= tail_vld_ff | push;
            head_ff     <= tail_vld_ff ? tail_ff : i_in_word;
            tail_vld_ff <= 1'b0;
         end else if (push) begin
            if (head_vld_ff) begin
               tail_vld_ff <= 1'b1;
               tail_ff     <= i_in_word;
            end else begin
               head_vld_ff <= 1'b1;
               head_ff     <= i_in_word;
            end
         end
      end
   end
endmodule

// file: echo_capture_timing.sv
// echo result packing, blanking gate, saturation timing and microsecond timer
`timescale 1ns/1ps
`include "echo_defs.svh"
module echo_capture_timing #(
   parameter int FIFO_BYTES = 768   // size of the fifo ram in bytes
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RESETN,
   // special-register port of the microcontroller
   input  wire logic [7:0]  I_REG_ADDR,
   input  wire logic [7:0]  I_REG_WDATA,
   input  wire logic        I_REG_WR,
   output logic      [7:0]  O_REG_RDATA,
   // raw data path output and limiter comparator
   input  wire logic [11:0] I_ECHO_DATA,
   input  wire logic        I_LIMITER_SENSE_BELOW,
   // data path control
   output logic             O_DATAPATH_RUN,
   output logic             O_FILTER_CLEAR,
   // fifo ram write port
   output logic             O_FIFO_WR_VALID,
   output logic      [9:0]  O_FIFO_WR_ADDR,
   output logic      [7:0]  O_FIFO_WR_DATA,
   input  wire logic        I_FIFO_WR_READY
);
   generate
      if (FIFO_BYTES < 2 || FIFO_BYTES > 1024) begin : g_bad_depth
         $error("FIFO_BYTES must lie in 2..1024");
      end
   endgenerate

   localparam logic [6:0] US_LAST  = 7'(`CYC_PER_US - 1);
   localparam logic [9:0] PTR_LAST = 10'(FIFO_BYTES - 1);
   localparam logic [3:0] COARSE_LAST = 4'(`US_PER_COARSE - 1);

   // software-written control
   logic        echo_en_ff;         // echo path enable
   logic        sat_measure_enable_ff;          // saturation measure enable
   echo_pkg::fifo_fmt_t fmt_ff;     // fifo storage format
   logic [7:0]  decim_ff;           // decimation_ratio
   logic [7:0]  blank_delay_ff;     // blanking delay in 16 us steps
   logic [7:0]  deglitch_ff;        // deglitch time in 2 us steps
   // block state
   logic [6:0]  us_div_ff;          // clock divider to one microsecond
   logic        us_tick_ff;         // one-cycle pulse each microsecond
   logic [15:0] frt_ff;             // free-running microsecond counter
   logic [15:0] snap_ff;            // freerun_snapshot
   logic [7:0]  dec_cnt_ff;         // clocks within one output sample
   logic [11:0] result_ff;          // echo result register
   logic        sample_ff;          // pulse: new result stored
   logic [3:0]  blank_us_ff;        // microseconds within one 16 us step
   logic [7:0]  blank_cnt_ff;       // elapsed 16 us steps of blanking
   logic        store_ok_ff;        // blanking over, writes allowed
   logic [3:0]  sat_us_ff;          // microseconds within one 16 us step
   logic [7:0]  sat_timer_ff;       // saturation timer in 16 us steps
   logic        dg_us_ff;           // microsecond within one 2 us step
   logic [7:0]  dg_cnt_ff;          // deglitch timer in 2 us steps
   logic [7:0]  sat_cap_ff;         // sat_time_capture
   logic        sat_measure_done_ff;        // sat_measure_done
   logic        overrun_ff;         // sample lost to a long stall
   logic [9:0]  wptr_ff;            // address of next byte to fill
   logic [7:0]  hi_byte_ff;         // second byte of a 12-bit sample
   echo_pkg::wr_state_t wr_st_ff;   // byte writer state
   echo_pkg::fifo_word_t wr_word_ff; // byte offered to the buffer
   logic [7:0]  rdata_ff;           // registered read data

   // register write decode
   wire wr_en    = I_REG_WR & (I_REG_ADDR == `REG_EN_CTRL);
   wire wr_fifo  = I_REG_WR & (I_REG_ADDR == `REG_FIFO_CTRL);
   wire wr_decim = I_REG_WR & (I_REG_ADDR == `REG_DECIM);
   wire wr_blank = I_REG_WR & (I_REG_ADDR == `REG_BLANK_DELAY);
   wire wr_dg    = I_REG_WR & (I_REG_ADDR == `REG_SAT_DEGLITCH);
   wire echo_rise = wr_en & I_REG_WDATA[`EN_ECHO_BIT] & ~echo_en_ff;
   wire sat_rise  = wr_en & I_REG_WDATA[`EN_SAT_BIT] & ~sat_measure_enable_ff;
   wire snap_req  = wr_en & I_REG_WDATA[`EN_SNAP_BIT];

   // timing enables
   wire coarse_blank = us_tick_ff & (blank_us_ff == COARSE_LAST);
   wire coarse_sat   = us_tick_ff & (sat_us_ff == COARSE_LAST);
   wire dg_tick      = us_tick_ff & dg_us_ff;
   wire dec_wrap     = (dec_cnt_ff >= decim_ff);

   // packing of the 12-bit result into the first fifo byte
   function automatic logic [7:0] pack_byte(input echo_pkg::fifo_fmt_t f, input logic [11:0] r);
      logic [7:0] b;
      b = r[7:0];
      unique case (f)
         echo_pkg::FMT_FULL12: b = r[7:0];
         echo_pkg::FMT_MSB8:   b = r[11:4];
         echo_pkg::FMT_LSB8:   b = (|r[11:8]) ? 8'hff : r[7:0];
         echo_pkg::FMT_MID8:   b = (|r[11:10]) ? 8'hff : r[10:3];
      endcase
      return b;
   endfunction

   wire        full12   = (fmt_ff == echo_pkg::FMT_FULL12);
   wire        buf_ready;
   wire        buf_valid;
   echo_pkg::fifo_word_t buf_word;
   wire        accept   = wr_st_ff != echo_pkg::WR_IDLE && buf_ready;
   wire        new_smp  = sample_ff & echo_en_ff & store_ok_ff;
   wire [9:0]  ptr_inc  = (wptr_ff == PTR_LAST) ? 10'h000 : wptr_ff + 10'h001;

   // read mux
   wire [7:0] rd_mux =
      (I_REG_ADDR == `REG_EN_CTRL)      ? {6'h00, sat_measure_enable_ff, echo_en_ff} :
      (I_REG_ADDR == `REG_FIFO_CTRL)    ? {6'h00, fmt_ff} :
      (I_REG_ADDR == `REG_DECIM)        ? decim_ff :
      (I_REG_ADDR == `REG_BLANK_DELAY)  ? blank_delay_ff :
      (I_REG_ADDR == `REG_SAT_DEGLITCH) ? deglitch_ff :
      (I_REG_ADDR == `REG_SAT_CAPTURE)  ? sat_cap_ff :
      (I_REG_ADDR == `REG_STATUS)       ? {6'h00, overrun_ff, sat_measure_done_ff} :
      (I_REG_ADDR == `REG_SNAP_LSB)     ? snap_ff[7:0] :
      (I_REG_ADDR == `REG_SNAP_MSB)     ? snap_ff[15:8] :
      (I_REG_ADDR == `REG_RESULT_LSB)   ? result_ff[7:0] :
      (I_REG_ADDR == `REG_RESULT_MSB)   ? {4'h0, result_ff[11:8]} : 8'h00;

   // control registers; the snapshot bit is a write-only pulse, never stored
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         echo_en_ff     <= 1'b0;
         sat_measure_enable_ff      <= 1'b0;
         fmt_ff         <= echo_pkg::FMT_FULL12;
         decim_ff       <= `RST_DECIM;
         blank_delay_ff <= `RST_BYTE;
         deglitch_ff    <= `RST_BYTE;
      end else begin
         if (wr_en) begin
            echo_en_ff <= I_REG_WDATA[`EN_ECHO_BIT];
            sat_measure_enable_ff  <= I_REG_WDATA[`EN_SAT_BIT];
         end
         if (wr_fifo) fmt_ff <= echo_pkg::fifo_fmt_t'(I_REG_WDATA[1:0]);
         if (wr_decim) decim_ff <= I_REG_WDATA;
         if (wr_blank) blank_delay_ff <= I_REG_WDATA;
         if (wr_dg) deglitch_ff <= I_REG_WDATA;
      end
   end

   // microsecond divider and free-running counter; wraps by natural overflow
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         us_div_ff  <= 7'h00;
         us_tick_ff <= 1'b0;
         frt_ff     <= `RST_WORD;
         snap_ff    <= `RST_WORD;
      end else begin
         us_tick_ff <= (us_div_ff == US_LAST);
         us_div_ff  <= (us_div_ff == US_LAST) ? 7'h00 : us_div_ff + 7'h01;
         if (us_tick_ff) frt_ff <= frt_ff + 16'h0001;
         // whole word in one edge, so both bytes read later agree
         if (snap_req) snap_ff <= frt_ff;
      end
   end

   // decimation: result register changes only once per output sample
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         dec_cnt_ff <= 8'h00;
         result_ff  <= 12'h000;
         sample_ff  <= 1'b0;
      end else if (!echo_en_ff) begin
         dec_cnt_ff <= 8'h00;
         sample_ff  <= 1'b0;
      end else begin
         dec_cnt_ff <= dec_wrap ? 8'h00 : dec_cnt_ff + 8'h01;
         sample_ff  <= dec_wrap;
         if (dec_wrap) result_ff <= I_ECHO_DATA;
      end
   end

   // blanking gate; restarts on every enable so a stale count never leaks
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         blank_us_ff  <= 4'h0;
         blank_cnt_ff <= 8'h00;
         store_ok_ff  <= 1'b0;
      end else if (echo_rise || !echo_en_ff) begin
         blank_us_ff  <= 4'h0;
         blank_cnt_ff <= 8'h00;
         store_ok_ff  <= 1'b0;
      end else if (!store_ok_ff) begin
         // zero delay opens the gate right after enable
         if (blank_cnt_ff == blank_delay_ff) begin
            store_ok_ff <= 1'b1;
         end else if (us_tick_ff) begin
            blank_us_ff <= blank_us_ff + 4'h1;
            if (coarse_blank) blank_cnt_ff <= blank_cnt_ff + 8'h01;
         end
      end
   end

   // saturation timer and deglitch
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         sat_us_ff    <= 4'h0;
         sat_timer_ff <= 8'h00;
         dg_us_ff     <= 1'b0;
         dg_cnt_ff    <= 8'h00;
         sat_cap_ff   <= 8'h00;
         sat_measure_done_ff  <= 1'b0;
      end else if (sat_rise || !sat_measure_enable_ff) begin
         sat_us_ff    <= 4'h0;
         sat_timer_ff <= 8'h00;
         dg_us_ff     <= 1'b0;
         dg_cnt_ff    <= 8'h00;
         sat_cap_ff   <= 8'h00;
         sat_measure_done_ff  <= 1'b0;
      end else if (!sat_measure_done_ff) begin
         if (us_tick_ff) sat_us_ff <= sat_us_ff + 4'h1;
         // saturates so a missing drop can never wrap the count
         if (coarse_sat && sat_timer_ff != `SAT_LIMIT) begin
            sat_timer_ff <= sat_timer_ff + 8'h01;
         end
         if (!I_LIMITER_SENSE_BELOW) begin
            dg_us_ff  <= 1'b0;
            dg_cnt_ff <= 8'h00;
         end else if (dg_cnt_ff >= deglitch_ff) begin
            sat_cap_ff  <= sat_timer_ff;
            sat_measure_done_ff <= 1'b1;
         end else if (us_tick_ff) begin
            dg_us_ff <= ~dg_us_ff;
            if (dg_tick) dg_cnt_ff <= dg_cnt_ff + 8'h01;
         end
      end
   end

   // data path run and filter clear follow the enable
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         O_DATAPATH_RUN <= 1'b0;
         O_FILTER_CLEAR <= 1'b1;
         rdata_ff       <= 8'h00;
      end else begin
         O_DATAPATH_RUN <= echo_en_ff;
         O_FILTER_CLEAR <= ~echo_en_ff;
         rdata_ff       <= rd_mux;
      end
   end
   assign O_REG_RDATA = rdata_ff;

   // byte writer: one byte per sample, or low then high for 12-bit
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         wr_st_ff   <= echo_pkg::WR_IDLE;
         wr_word_ff <= '0;
         hi_byte_ff <= 8'h00;
         wptr_ff    <= 10'h000;
         overrun_ff <= 1'b0;
      end else if (echo_rise) begin
         wptr_ff    <= 10'h000;
         wr_st_ff   <= echo_pkg::WR_IDLE;
         overrun_ff <= 1'b0;
      end else if (!echo_en_ff) begin
         wr_st_ff <= echo_pkg::WR_IDLE;
      end else begin
         unique case (wr_st_ff)
            echo_pkg::WR_IDLE: begin
               if (new_smp) begin
                  wr_word_ff <= '{addr: wptr_ff, data: pack_byte(fmt_ff, result_ff)};
                  hi_byte_ff <= {4'h0, result_ff[11:8]};
                  wr_st_ff   <= echo_pkg::WR_BYTE0;
               end
            end
            echo_pkg::WR_BYTE0: begin
               if (new_smp) overrun_ff <= 1'b1;          // stall longer than a sample
               if (accept) begin
                  wptr_ff <= ptr_inc;
                  if (full12) begin
                     wr_word_ff <= '{addr: ptr_inc, data: hi_byte_ff};
                     wr_st_ff   <= echo_pkg::WR_BYTE1;
                  end else begin
                     wr_st_ff <= echo_pkg::WR_IDLE;
                  end
               end
            end
            echo_pkg::WR_BYTE1: begin
               if (new_smp) overrun_ff <= 1'b1;
               if (accept) begin
                  wptr_ff  <= ptr_inc;
                  wr_st_ff <= echo_pkg::WR_IDLE;
               end
            end
         endcase
      end
   end

   // buffer absorbs short stalls of the ram port
   pair_buffer u_buf (
      .i_clk       (I_SYS_CLK),
      .i_rst_n     (I_RESETN),
      .i_in_valid  (wr_st_ff != echo_pkg::WR_IDLE),
      .i_in_word   (wr_word_ff),
      .o_in_ready  (buf_ready),
      .o_out_valid (buf_valid),
      .o_out_word  (buf_word),
      .i_out_ready (I_FIFO_WR_READY)
   );
   assign O_FIFO_WR_VALID = buf_valid;
   assign O_FIFO_WR_ADDR  = buf_word.addr;
   assign O_FIFO_WR_DATA  = buf_word.data;
endmodule

// file: fifo_ram_model.sv
// behavioural fifo ram on the far side of the byte write port
`timescale 1ns/1ps
module fifo_ram_model #(
   parameter int DEPTH = 768        // bytes of storage
) (
   input  wire logic       i_clk,
   input  wire logic       i_stall,   // allows random back-pressure
   input  wire logic       i_valid,
   input  wire logic [9:0] i_addr,
   input  wire logic [7:0] i_data,
   output logic            o_ready
);
   logic [7:0] mem [DEPTH];          // contents survive re-enables
   initial o_ready = 1'b1;
   // ready drops at random only while stalling is allowed
   always @(posedge i_clk) begin
      o_ready <= i_stall ? 1'($urandom % 2) : 1'b1;
   end
   // store each accepted byte
   always @(posedge i_clk) begin
      if (i_valid && o_ready) begin
         mem[i_addr] <= i_data;
      end
   end
endmodule

// file: echo_capture_timing_properties.sv
// port assertions for the echo control block and their bind
`timescale 1ns/1ps
`include "echo_defs.svh"
module echo_capture_timing_chk #(
   parameter int FIFO_BYTES = 768   // fifo size in bytes
) (
   input wire logic        I_SYS_CLK,
   input wire logic        I_RESETN,
   input wire logic [7:0]  I_REG_ADDR,
   input wire logic [7:0]  I_REG_WDATA,
   input wire logic        I_REG_WR,
   input wire logic [7:0]  O_REG_RDATA,
   input wire logic [11:0] I_ECHO_DATA,
   input wire logic        I_LIMITER_SENSE_BELOW,
   input wire logic        O_DATAPATH_RUN,
   input wire logic        O_FILTER_CLEAR,
   input wire logic        O_FIFO_WR_VALID,
   input wire logic [9:0]  O_FIFO_WR_ADDR,
   input wire logic [7:0]  O_FIFO_WR_DATA,
   input wire logic        I_FIFO_WR_READY
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESETN);
   wire        acc   = O_FIFO_WR_VALID && I_FIFO_WR_READY;       // byte taken by the ram
   wire        en_wr = I_REG_WR && (I_REG_ADDR == `REG_EN_CTRL); // enable register write
   logic [9:0] last_ff;  // address of the last byte taken
   logic       seen_ff;  // a byte was taken since echo enable
   logic [4:0] idle_ff;  // clocks stopped, saturating
   // last address, forgotten on each echo enable
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN || (en_wr && I_REG_WDATA[`EN_ECHO_BIT])) seen_ff <= 1'b0;
      else if (acc) seen_ff <= 1'b1;
      if (acc) last_ff <= O_FIFO_WR_ADDR;
   end
   // idle count gives the buffer time to drain before writes must stop
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN || O_DATAPATH_RUN) idle_ff <= 5'h00;
      else if (idle_ff != 5'h1f) idle_ff <= idle_ff + 5'h01;
   end
   // run unchanged over two clocks, so latency skew cannot matter
   sequence run_steady_s;
      $stable(O_DATAPATH_RUN) ##1 $stable(O_DATAPATH_RUN);
   endsequence
   // saturation disable, then a read of address a
   sequence sat_off_s(logic [7:0] a);
      en_wr && !I_REG_WDATA[`EN_SAT_BIT] ##2 I_REG_ADDR == a;
   endsequence
   // snapshot high byte addressed with no write
   sequence snap_idle_s;
      (I_REG_ADDR == `REG_SNAP_MSB && !I_REG_WR) [*3];
   endsequence
   run_on_a: assert property (en_wr && I_REG_WDATA[`EN_ECHO_BIT] |-> ##[1:2] O_DATAPATH_RUN)
      else $error("data path did not start");
   run_off_a: assert property (en_wr && !I_REG_WDATA[`EN_ECHO_BIT] |-> ##[1:2] !O_DATAPATH_RUN)
      else $error("data path did not stop");
   clear_idle_a: assert property (run_steady_s |-> $past(O_FILTER_CLEAR) != O_DATAPATH_RUN)
      else $error("filter clear disagrees with run");
   idle_write_a: assert property (idle_ff == 5'h1f |-> !O_FIFO_WR_VALID)
      else $error("fifo written while stopped");
   write_hold_a: assert property (O_FIFO_WR_VALID && !I_FIFO_WR_READY |=>
      O_FIFO_WR_VALID && $stable({O_FIFO_WR_ADDR, O_FIFO_WR_DATA}))
      else $error("stalled write changed");
   addr_step_a: assert property (acc && seen_ff |->
      O_FIFO_WR_ADDR == ((last_ff == 10'(FIFO_BYTES - 1)) ? 10'h000 : last_ff + 10'h001))
      else $error("fifo address did not step by one");
   addr_first_a: assert property (acc && !seen_ff |-> O_FIFO_WR_ADDR == 10'h000)
      else $error("first byte not at address zero");
   unmapped_read_a: assert property (I_REG_ADDR > `REG_RESULT_MSB |=> O_REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   sat_measure_done_a: assert property (sat_off_s(`REG_STATUS) |=> !O_REG_RDATA[`ST_SAT_MEASURE_DONE_BIT])
      else $error("done flag survived disable");
   sat_cap_a: assert property (sat_off_s(`REG_SAT_CAPTURE) |=> O_REG_RDATA == 8'h00)
      else $error("capture survived disable");
   snap_hold_a: assert property (snap_idle_s |=> $stable(O_REG_RDATA))
      else $error("snapshot changed without request");
endmodule
bind echo_capture_timing echo_capture_timing_chk #(.FIFO_BYTES(FIFO_BYTES)) u_chk (
   .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
   .I_REG_WR(I_REG_WR), .O_REG_RDATA(O_REG_RDATA), .I_ECHO_DATA(I_ECHO_DATA),
   .I_LIMITER_SENSE_BELOW(I_LIMITER_SENSE_BELOW), .O_DATAPATH_RUN(O_DATAPATH_RUN),
   .O_FILTER_CLEAR(O_FILTER_CLEAR), .O_FIFO_WR_VALID(O_FIFO_WR_VALID), .O_FIFO_WR_ADDR(O_FIFO_WR_ADDR),
   .O_FIFO_WR_DATA(O_FIFO_WR_DATA), .I_FIFO_WR_READY(I_FIFO_WR_READY)
);

// file: echo_capture_timing_tb_top.sv
// self-checking bench for the echo control block
`timescale 1ns/1ps
`include "echo_defs.svh"
module echo_capture_timing_tb_top;
   localparam int DEC = 15;        // one sample per 16 clocks
   logic        sys_clk = 1'b0;    // 125 mhz clock
   logic        rst_n   = 1'b0;    // synchronous reset
   logic [7:0]  addr    = 8'h00;   // register address
   logic [7:0]  wdata   = 8'h00;   // register write data
   logic        wr      = 1'b0;    // write strobe
   logic [11:0] echo    = 12'h000; // data path result
   logic        below   = 1'b0;    // limiter under threshold
   logic        stall   = 1'b0;    // lets the ram stall
   logic        gap_chk = 1'b0;    // checks sample spacing
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc_n = 0;         // clock count
   int          last_acc = 0;      // clock of last accepted byte
   wire  [7:0]  rdata;
   wire         run, fclr, wvalid, wready;
   wire  [9:0]  waddr;
   wire  [7:0]  wdat;
   echo_pkg::fifo_word_t exp_q[$]; // expected ram writes, oldest first

   always #4 sys_clk = ~sys_clk;

   echo_capture_timing uut (
      .I_SYS_CLK(sys_clk), .I_RESETN(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
      .O_REG_RDATA(rdata), .I_ECHO_DATA(echo), .I_LIMITER_SENSE_BELOW(below), .O_DATAPATH_RUN(run),
      .O_FILTER_CLEAR(fclr), .O_FIFO_WR_VALID(wvalid), .O_FIFO_WR_ADDR(waddr), .O_FIFO_WR_DATA(wdat),
      .I_FIFO_WR_READY(wready)
   );
   fifo_ram_model ram (
      .i_clk(sys_clk), .i_stall(stall), .i_valid(wvalid), .i_addr(waddr), .i_data(wdat), .o_ready(wready)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // write strobe for one clock, then one quiet clock
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // read data is registered, so look after the sampling edge
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
      addr <= a;
      @(posedge sys_clk);
      @(negedge sys_clk);
      v = rdata;
      @(posedge sys_clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      reg_rd(a, v);
      check(v, e);
   endtask
   // request a snapshot and read both halves, high byte twice
   task automatic snap(output logic [15:0] t);
      logic [7:0] v;
      reg_wr(`REG_EN_CTRL, 8'h04);
      reg_rd(`REG_SNAP_LSB, t[7:0]);
      reg_rd(`REG_SNAP_MSB, t[15:8]);
      reg_rd(`REG_SNAP_MSB, v);
      check(v, t[15:8]);
   endtask
   function automatic logic [7:0] fmt_byte(input logic [1:0] f, input logic [11:0] d);
      case (f)
         2'b01:   return d[11:4];
         2'b10:   return (d[11:8] != 4'h0) ? 8'hff : d[7:0];
         2'b11:   return (d[11:10] != 2'b00) ? 8'hff : d[10:3];
         default: return d[7:0];
      endcase
   endfunction
   // one enable period in format f with constant data d
   task automatic run_fmt(input logic [1:0] f, input logic [11:0] d, input logic st);
      int k;
      echo_pkg::fifo_word_t w;
      echo <= d;
      stall <= st;
      gap_chk <= !st && (f != 2'b00);
      reg_wr(`REG_FIFO_CTRL, {6'h00, f});
      for (k = 0; k < ((f == 2'b00) ? 6 : 3); k++) begin
         w.addr = 10'(k);
         w.data = (f != 2'b00) ? fmt_byte(f, d) : (k % 2) ? {4'h0, d[11:8]} : d[7:0];
         exp_q.push_back(w);
      end
      last_acc = 0;
      reg_wr(`REG_EN_CTRL, 8'h01);
      for (k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge sys_clk);
      if (exp_q.size() > 0) begin
         n_mismatch++;
         wrap_up();
      end
      rd_chk(`REG_RESULT_LSB, d[7:0]);
      rd_chk(`REG_RESULT_MSB, {4'h0, d[11:8]});
      reg_wr(`REG_EN_CTRL, 8'h00);
      cyc(60);
   endtask
   // scoreboard: each accepted byte, while notes remain, against the oldest note
   always @(posedge sys_clk) begin
      if (rst_n && wvalid && wready) begin
         if (exp_q.size() > 0) check({waddr, wdat}, exp_q.pop_front());
         if (gap_chk && last_acc > 0) check(cyc_n - last_acc, DEC + 1);
         last_acc = cyc_n;
      end
      cyc_n++;
   end

   initial begin
      int          k;
      logic [7:0]  v;
      logic [15:0] t0;
      logic [15:0] t1;
      void'($urandom(32'h82b2ec74));
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      check(fclr, 1'b1);
      check(run, 1'b0);
      snap(t0);
      check(t0, 16'h0000);
      rd_chk(`REG_DECIM, `RST_DECIM);
      rd_chk(`REG_BLANK_DELAY, `RST_BYTE);
      rd_chk(8'hc3, 8'h00);
      reg_wr(`REG_SAT_CAPTURE, 8'h77);
      rd_chk(`REG_SAT_CAPTURE, 8'h00);
      reg_wr(`REG_SAT_DEGLITCH, 8'ha5);
      rd_chk(`REG_SAT_DEGLITCH, 8'ha5);
      reg_wr(`REG_DECIM, 8'(DEC));
      cyc(1000);
      snap(t1);
      check(t1 - t0 >= 8 && t1 - t0 <= 9, 1'b1);
      // every format, plain and clamped data, the second under stalls
      for (k = 0; k < 4; k++) begin
         run_fmt(2'(k), 12'($urandom) & 12'h0ff, 1'b0);
         run_fmt(2'(k), 12'($urandom) | 12'h800, 1'b1);
      end
      // first write waits out two blanking steps
      reg_wr(`REG_BLANK_DELAY, 8'h02);
      reg_wr(`REG_EN_CTRL, 8'h01);
      for (k = 0; k < 6000 && wvalid !== 1'b1; k++) @(posedge sys_clk);
      check(k > 1900 && k <= 4100, 1'b1);
      if (k == 6000) wrap_up();
      reg_wr(`REG_EN_CTRL, 8'h00);
      // saturation: a short dip must not count, a long one captures
      reg_wr(`REG_SAT_DEGLITCH, 8'h03);
      reg_wr(`REG_EN_CTRL, 8'h02);
      cyc(5800);
      // no drop yet: done low, capture still reads zero
      reg_rd(`REG_STATUS, v);
      check(v[0], 1'b0);
      rd_chk(`REG_SAT_CAPTURE, 8'h00);
      below <= 1'b1;
      cyc(370);
      below <= 1'b0;
      reg_rd(`REG_STATUS, v);
      check(v[0], 1'b0);
      // both dips together exceed the deglitch time, so a kept count would trip
      below <= 1'b1;
      cyc(500);
      reg_rd(`REG_STATUS, v);
      check(v[0], 1'b0);
      cyc(700);
      reg_rd(`REG_STATUS, v);
      check(v[0], 1'b1);
      reg_rd(`REG_SAT_CAPTURE, v);
      check(v >= 2 && v <= 4, 1'b1);
      reg_wr(`REG_EN_CTRL, 8'h00);
      rd_chk(`REG_SAT_CAPTURE, 8'h00);
      reg_wr(`REG_EN_CTRL, 8'h02);
      reg_wr(`REG_EN_CTRL, 8'h00);
      reg_rd(`REG_STATUS, v);
      check(v[0], 1'b0);
      wrap_up();
   end
endmodule
